// ===== hdl/i2csr_core.sv
// Two-wire slave receiver with AXI4-Lite register access.
// Assumes SCL and SDA arrive asynchronously; open-drain pads pull low while an enable is high.
// Arbitration loss and sleep indications come from logic on aclk.
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "i2csr_map.svh"

// Overview of operation
// - Status codes always have prescaler bits zero
// - Upper seven own-address bits form slave address
// - Address bit zero enables general call response
// - Acknowledge address only with ack enable set
// - Write bit enters receiver, read goes transmitter
// - Own address with write sets flag, status
// - Arbitration loss then address gives 0x68/0x78
// - Cleared ack enable gives NACK after byte
// - Ack enable zero ignores address, resumes later
// - Address matching still works while core sleeps
// - Sleep match requests wake, holds SCL low
// - Data register may be stale after wake
// - Own address write acknowledged reports 0x60
// - Lost arbitration, own address reports 0x68
// - General call acknowledged reports 0x70
// - Lost arbitration, general call reports 0x78
// - Data byte acknowledged reports 0x80
// - Flag clear receives next byte, ack per enable
// - Data byte not acknowledged reports 0x88
// - After 0x88 clear becomes unaddressed slave
// - Start bit set: start once bus free
module i2csr_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output i2csr_pkg::i2csr_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output i2csr_pkg::i2csr_resp_t rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe,
  output logic sda_oe,
  input wire logic core_sleep,
  input wire logic arb_lost,
  output logic wake_request,
  output logic tx_select,
  output logic start_on_free
);
  import i2csr_pkg::*;

  // ==========================================================================
  // Pin synchronisers and bus events
  logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
  wire scl_rise = scl_s2_r & ~scl_d_r;
  wire scl_fall = ~scl_s2_r & scl_d_r;
  wire bus_start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  wire bus_stop = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

  // Two stages before any use; a third stage gives the edge reference
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_d_r} <= 3'h7;
    end else begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= {scl_i, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_d_r} <= {sda_i, sda_s1_r, sda_s2_r};
    end
  end

  // ==========================================================================
  // Registers and bus slave state
  i2csr_state_t state_r, state_nxt;
  i2csr_byte_t own_r, data_r, status_r, shift_r;
  logic flag_r, ack_en_r, start_r, stop_r, wcol_r, en_r, int_en_r;
  logic [3:0] cnt_r;
  logic gc_r, nack_r, arb_seen_r, busy_r, flag_set;
  logic aw_got_r, w_got_r;
  logic [7:0] waddr_r;
  logic [7:0] wbyte_r;
  logic wstrb0_r;

  // ==========================================================================
  // Register decode
  wire do_write = aw_got_r & w_got_r & ~bvalid;
  wire wr_own = do_write & wstrb0_r & (waddr_r == `I2CSR_OFS_OWN_ADDR);
  wire wr_ctl = do_write & wstrb0_r & (waddr_r == `I2CSR_OFS_CONTROL);
  wire wr_data = do_write & wstrb0_r & (waddr_r == `I2CSR_OFS_DATA);
  wire wr_hit = (waddr_r == `I2CSR_OFS_OWN_ADDR) | (waddr_r == `I2CSR_OFS_CONTROL) |
                (waddr_r == `I2CSR_OFS_STATUS) | (waddr_r == `I2CSR_OFS_DATA);
  wire [7:0] ctl_view = {flag_r, ack_en_r, start_r, stop_r, wcol_r, en_r, 1'b0, int_en_r};
  wire rd_hit = (araddr == `I2CSR_OFS_OWN_ADDR) | (araddr == `I2CSR_OFS_CONTROL) |
                (araddr == `I2CSR_OFS_STATUS) | (araddr == `I2CSR_OFS_DATA);
  wire [7:0] rd_byte = (araddr == `I2CSR_OFS_OWN_ADDR) ? own_r :
                       (araddr == `I2CSR_OFS_CONTROL) ? ctl_view :
                       (araddr == `I2CSR_OFS_STATUS) ? status_r :
                       (araddr == `I2CSR_OFS_DATA) ? data_r : 8'h00;
  wire sw_clr_flag = wr_ctl & wbyte_r[`I2CSR_CTL_FLAG];

  // ==========================================================================
  // Address and acknowledge decisions
  wire own_match = (shift_r[7:1] == own_r[7:1]);
  wire gc_match = (shift_r[7:1] == `I2CSR_GC_ADDR) & own_r[0];
  // Matching uses only the bus edges, so it keeps working while the core sleeps
  wire addr_hit = en_r & ack_en_r & (own_match | gc_match);
  wire byte_done = scl_fall & (cnt_r == `I2CSR_BITS_PER_BYTE);
  wire [7:0] gc_code = arb_seen_r ? `I2CSR_ST_ARB_GC_ACK : `I2CSR_ST_GC_ACK;
  wire [7:0] own_code = arb_seen_r ? `I2CSR_ST_ARB_OWN_ACK : `I2CSR_ST_OWN_ACK;
  wire [7:0] addr_code = gc_r ? gc_code : own_code;
  wire [7:0] data_code = gc_r ? (nack_r ? `I2CSR_ST_GC_DATA_NACK : `I2CSR_ST_GC_DATA_ACK) :
                         (nack_r ? `I2CSR_ST_DATA_NACK : `I2CSR_ST_DATA_ACK);

  // Next state of the receiver sequence
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: state_nxt = ST_IDLE;
      ST_ADDR:
        if (byte_done) begin
          state_nxt = (addr_hit & ~shift_r[0]) ? ST_ADDR_ACK : ST_IDLE;
        end
      ST_ADDR_ACK:
        if (scl_fall) begin
          state_nxt = ST_HOLD;
        end
      ST_HOLD:
        if (!flag_r) begin
          state_nxt = nack_r ? ST_IDLE : ST_DATA;
        end
      ST_DATA:
        if (byte_done) begin
          state_nxt = ST_DATA_ACK;
        end
      ST_DATA_ACK:
        if (scl_fall) begin
          state_nxt = ST_HOLD;
        end
    endcase
    if (bus_start && en_r) begin
      state_nxt = ST_ADDR;
    end else if (bus_stop || !en_r || stop_r) begin
      state_nxt = ST_IDLE;
    end
  end

  assign flag_set = scl_fall & ((state_r == ST_ADDR_ACK) | (state_r == ST_DATA_ACK));

  // Sequence state and shift register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      shift_r <= 8'h00;
      cnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) begin
        cnt_r <= 4'h0;
      end else if (scl_rise && ((state_r == ST_ADDR) || (state_r == ST_DATA))) begin
        cnt_r <= cnt_r + 4'h1;
        shift_r <= {shift_r[6:0], sda_s2_r};
      end
    end
  end

  // ==========================================================================
  // Transfer context: general call, refusal, arbitration, transmitter select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gc_r <= 1'b0;
      nack_r <= 1'b0;
      arb_seen_r <= 1'b0;
      tx_select <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      busy_r <= bus_start | (busy_r & ~bus_stop);
      if (state_r == ST_ADDR && byte_done) begin
        gc_r <= ~own_match;
        nack_r <= 1'b0;
        tx_select <= addr_hit & shift_r[0];
      end else if (bus_stop) begin
        tx_select <= 1'b0;
      end
      if (state_r == ST_DATA && byte_done) begin
        nack_r <= ~ack_en_r;
      end
      // Loss of arbitration is remembered until the next addressing is reported or a STOP is seen
      if (arb_lost) begin
        arb_seen_r <= 1'b1;
      end else if (bus_stop || (flag_set && state_r == ST_ADDR_ACK)) begin
        arb_seen_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Open-drain drivers: acknowledge and clock stretching
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      if (state_r == ST_ADDR && byte_done) begin
        sda_oe <= addr_hit & ~shift_r[0];
      end else if (state_r == ST_DATA && byte_done) begin
        sda_oe <= ack_en_r;
      end else if (scl_fall || state_nxt == ST_IDLE) begin
        sda_oe <= 1'b0;
      end
      // Stretch from the end of the acknowledge bit until software clears the flag
      if (flag_set) begin
        scl_oe <= 1'b1;
      end else if (!flag_r || state_nxt == ST_IDLE) begin
        scl_oe <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Serial control: flag set wins over the software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {flag_r, ack_en_r, start_r, stop_r, wcol_r, en_r, int_en_r} <= 7'h00;
    end else begin
      flag_r <= flag_set | (flag_r & ~sw_clr_flag);
      if (wr_ctl) begin
        ack_en_r <= wbyte_r[`I2CSR_CTL_ACK_EN];
        start_r <= wbyte_r[`I2CSR_CTL_START];
        en_r <= wbyte_r[`I2CSR_CTL_ENABLE];
        int_en_r <= wbyte_r[`I2CSR_CTL_INT_EN];
      end
      // A stop request only recovers the slave, then clears itself
      stop_r <= wr_ctl & wbyte_r[`I2CSR_CTL_STOP];
      if (wr_data) begin
        wcol_r <= ~flag_r; // Data written with the flag low is a collision
      end
    end
  end

  // Status, data, address and wake request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= `I2CSR_ST_NO_INFO;
      data_r <= `I2CSR_RST_DATA;
      own_r <= `I2CSR_RST_OWN_ADDR;
      wake_request <= 1'b0;
      start_on_free <= 1'b0;
    end else begin
      if (flag_set) begin
        status_r <= (state_r == ST_ADDR_ACK) ? addr_code : data_code;
      end else if (sw_clr_flag) begin
        status_r <= `I2CSR_ST_NO_INFO;
      end
      // Address bytes never reach the data register, so it may be stale after a wake
      if (state_r == ST_DATA && byte_done) begin
        data_r <= shift_r;
      end else if (wr_data && flag_r) begin
        data_r <= wbyte_r;
      end
      if (wr_own) begin
        own_r <= wbyte_r;
      end
      if (flag_set && state_r == ST_ADDR_ACK && core_sleep) begin
        wake_request <= 1'b1;
      end else if (sw_clr_flag || state_nxt == ST_IDLE) begin
        // Dropped with the flag, so a wake never outlives the clock hold
        wake_request <= 1'b0;
      end
      start_on_free <= start_r & en_r & ~busy_r & (state_r == ST_IDLE);
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel: address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `I2CSR_RESP_OKAY;
      waddr_r <= 8'h00;
      wbyte_r <= 8'h00;
      wstrb0_r <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_got_r <= 1'b1;
        waddr_r <= awaddr;
      end else if (!aw_got_r && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_got_r <= 1'b1;
        wbyte_r <= wdata[7:0];
        wstrb0_r <= wstrb[0];
      end else if (!w_got_r && !bvalid) begin
        wready <= 1'b1;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? `I2CSR_RESP_OKAY : `I2CSR_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel: one read at a time, data one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `I2CSR_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, rd_byte};
        rresp <= rd_hit ? `I2CSR_RESP_OKAY : `I2CSR_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Checks
  a_status_prescaler_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    status_r[2:0] == 3'h0) else $error("Status prescaler bits not zero");
  a_ack_address_match: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_ADDR && byte_done && !shift_r[0] && en_r && ack_en_r && own_match)
    |=> state_r == ST_ADDR_ACK && sda_oe) else $error("Own address not acknowledged");
  a_gc_needs_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_ADDR && byte_done && shift_r[7:1] == 7'h00 && !own_r[0])
    |=> state_r == ST_IDLE && !sda_oe) else $error("General call taken while off");
  a_no_ack_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_ADDR && byte_done && !ack_en_r) |=> !sda_oe ##1 !flag_set)
    else $error("Address acknowledged with ack enable low");
  a_read_not_received: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_ADDR && byte_done && shift_r[0]) |=> state_r != ST_ADDR_ACK)
    else $error("Read direction entered receiver");
  a_addr_flag_code: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_ADDR_ACK && scl_fall) |=> flag_r && scl_oe &&
    (status_r == (gc_r ? ($past(arb_seen_r) ? 8'h78 : 8'h70) : ($past(arb_seen_r) ? 8'h68 : 8'h60))))
    else $error("Wrong addressing status");
  a_data_nack: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_DATA && byte_done && !ack_en_r) |=> state_r == ST_DATA_ACK && !sda_oe)
    else $error("Data acknowledged with ack enable low");
  a_data_code: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_DATA_ACK && scl_fall && !gc_r) |=> flag_r &&
    (status_r == (nack_r ? 8'h88 : 8'h80)) && data_r == $past(data_r))
    else $error("Wrong data status");
  a_stretch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (flag_r && state_r == ST_HOLD && !sw_clr_flag && !bus_start && !bus_stop && !stop_r && en_r)
    |=> scl_oe) else $error("Clock released while flag set");
  a_wake_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_request |-> flag_r && scl_oe) else $error("Wake without clock hold");
  a_unaddressed_exit: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_HOLD && !flag_r && nack_r && !bus_start) |=> state_r == ST_IDLE)
    else $error("Not left addressed state after refusal");
  a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_set |=> flag_r) else $error("Flag event lost");
endmodule // i2csr_core

// ===== hdl/i2csr_map.svh
// Register offsets, field positions, reset values and status codes of the slave receiver.
// Assumes a 32-bit AXI4-Lite slave with byte addresses and one word for each register.
`ifndef I2CSR_MAP_SVH
`define I2CSR_MAP_SVH
// ==========================================================================
// Register byte offsets
`define I2CSR_OFS_OWN_ADDR 8'h00
`define I2CSR_OFS_CONTROL 8'h04
`define I2CSR_OFS_STATUS 8'h08
`define I2CSR_OFS_DATA 8'h0c
// ==========================================================================
// Control field positions
`define I2CSR_CTL_FLAG 7
`define I2CSR_CTL_ACK_EN 6
`define I2CSR_CTL_START 5
`define I2CSR_CTL_STOP 4
`define I2CSR_CTL_WCOL 3
`define I2CSR_CTL_ENABLE 2
`define I2CSR_CTL_INT_EN 0
// ==========================================================================
// Reset values
`define I2CSR_RST_OWN_ADDR 8'hfe
`define I2CSR_RST_CONTROL 8'h00
`define I2CSR_RST_DATA 8'hff
// ==========================================================================
// Status codes, prescaler bits always zero
`define I2CSR_ST_OWN_ACK 8'h60
`define I2CSR_ST_ARB_OWN_ACK 8'h68
`define I2CSR_ST_GC_ACK 8'h70
`define I2CSR_ST_ARB_GC_ACK 8'h78
`define I2CSR_ST_DATA_ACK 8'h80
`define I2CSR_ST_DATA_NACK 8'h88
`define I2CSR_ST_GC_DATA_ACK 8'h90
`define I2CSR_ST_GC_DATA_NACK 8'h98
`define I2CSR_ST_NO_INFO 8'hf8
`define I2CSR_GC_ADDR 7'h00
`define I2CSR_BITS_PER_BYTE 4'h8
// ==========================================================================
// AXI responses
`define I2CSR_RESP_OKAY 2'h0
`define I2CSR_RESP_SLVERR 2'h2
`endif

// ===== hdl/i2csr_pkg.sv
// Types shared by the two-wire slave receiver.
// Assumes the map header is included by every user of these types.
package i2csr_pkg;
  // ==========================================================================
  // Receiver sequence
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_HOLD,
    ST_DATA,
    ST_DATA_ACK
  } i2csr_state_t;
  typedef logic [1:0] i2csr_resp_t;
  typedef logic [7:0] i2csr_byte_t;
endpackage

// ===== verification/i2csr_bus_master.sv
// Behavioural two-wire bus master transmitter that drives the far side of the slave receiver.
// Assumes open-drain lines with pull-ups resolved outside; a pull output high drives its line low.
`timescale 1ns/1ps

module i2csr_bus_master (
  input wire logic aclk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull
);
  // ==========================================================================
  // Bus timing helpers, one bit is 20 aclk cycles (160 ns)
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Release SCL and wait while the slave stretches; bounded so a stuck line cannot hang us
  task automatic rise();
    int t;
    scl_pull <= 1'b0;
    t = 0;
    tick(1);
    while (!scl && t < 400) begin
      tick(1);
      t++;
    end
    tick(9);
  endtask

  // ==========================================================================
  // Conditions and bytes
  task automatic start();
    sda_pull <= 1'b1;
    tick(10);
    scl_pull <= 1'b1;
    tick(5);
  endtask

  task automatic stop();
    sda_pull <= 1'b1;
    tick(5);
    rise();
    sda_pull <= 1'b0;
    tick(10);
  endtask

  // MSB first; ack is 1 when the slave pulled SDA low in the ninth bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_pull <= !b[i];
      tick(5);
      rise();
      scl_pull <= 1'b1;
      tick(5);
    end
    sda_pull <= 1'b0;
    tick(5);
    rise();
    ack = !sda;
    scl_pull <= 1'b1;
    tick(10);
  endtask
endmodule // i2csr_bus_master

// ===== verification/testbench.sv
// Self-checking bench for the slave receiver: AXI4-Lite register master plus a bus master model.
// Assumes the design's embedded assertions; register results are checked through a queue.
`timescale 1ns/1ps
`include "i2csr_map.svh"

module testbench;
  import i2csr_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, core_sleep, arb_lost;
  logic [7:0] awaddr, araddr, d;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe;
  logic wake_request, tx_select, start_on_free, scl_pull, sda_pull, ack;
  logic [6:0] sa;
  i2csr_resp_t bresp, rresp;
  wire scl;
  wire sda;
  logic [33:0] exp_q[$];
  int error_cnt, n_checks;

  // Open-drain lines with pull-ups
  assign scl = !(scl_pull || scl_oe);
  assign sda = !(sda_pull || sda_oe);

  i2csr_core i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .scl_i(scl), .sda_i(sda), .scl_oe(scl_oe), .sda_oe(sda_oe), .core_sleep(core_sleep),
    .arb_lost(arb_lost), .wake_request(wake_request), .tx_select(tx_select),
    .start_on_free(start_on_free));
  i2csr_bus_master i_master (.aclk(aclk), .scl(scl), .sda(sda), .scl_pull(scl_pull),
    .sda_pull(sda_pull));

  // ==========================================================================
  // Checking and verdict
  task automatic chk(input logic [33:0] g, input logic [33:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic give_verdict();
    if (exp_q.size() != 0) error_cnt++;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Each register response takes the oldest note off the queue
  always @(posedge aclk) begin
    if ((rvalid && rready) || (bvalid && bready)) begin
      if (exp_q.size() == 0) chk(34'h0, 34'h1, "unexpected response");
      else chk(rvalid ? {rresp, rdata} : {bresp, 32'h0}, exp_q.pop_front(), "register response");
    end
  end

  // ==========================================================================
  // AXI4-Lite master tasks; each waits for its own answer under a bound
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input i2csr_resp_t er);
    int t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    exp_q.push_back({er, 32'h0});
    t = 0;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      t++;
    end while (!bvalid && t < 100);
    if (t >= 100) error_cnt++; // A lost answer counts as a mismatch
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] v, input i2csr_resp_t er);
    int t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    exp_q.push_back({er, 24'h0, v});
    t = 0;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      t++;
    end while (!rvalid && t < 100);
    if (t >= 100) error_cnt++; // A lost answer counts as a mismatch
    rready <= 1'b0;
  endtask

  // One byte on the bus, optionally after a START
  task automatic xfer(input logic s, input logic [7:0] b);
    if (s) i_master.start();
    i_master.send_byte(b, ack);
  endtask

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Watchdog: the sequence needs roughly 3000 cycles
  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    give_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, core_sleep, arb_lost} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    void'($urandom(13092));
    repeat (2) @(posedge aclk);
    rd(`I2CSR_OFS_OWN_ADDR, 8'hfe, `I2CSR_RESP_OKAY);
    rd(`I2CSR_OFS_CONTROL, 8'h00, `I2CSR_RESP_OKAY);
    rd(`I2CSR_OFS_STATUS, 8'hf8, `I2CSR_RESP_OKAY);
    rd(`I2CSR_OFS_DATA, 8'hff, `I2CSR_RESP_OKAY);
    rd(8'h10, 8'h00, `I2CSR_RESP_SLVERR);
    wr(8'h10, 8'h55, `I2CSR_RESP_SLVERR);
    sa = 7'($urandom_range(1, 126));
    wr(`I2CSR_OFS_OWN_ADDR, {sa, 1'b1}, `I2CSR_RESP_OKAY);
    rd(`I2CSR_OFS_OWN_ADDR, {sa, 1'b1}, `I2CSR_RESP_OKAY);
    wr(`I2CSR_OFS_CONTROL, 8'h44, `I2CSR_RESP_OKAY);
    xfer(1'b1, {sa, 1'b0});
    chk(ack, 1, "own address ack");
    chk(scl_oe, 1, "stretch while flag set");
    rd(`I2CSR_OFS_STATUS, 8'h60, `I2CSR_RESP_OKAY);
    rd(`I2CSR_OFS_CONTROL, 8'hc4, `I2CSR_RESP_OKAY);
    repeat (2) begin
      wr(`I2CSR_OFS_CONTROL, 8'hc4, `I2CSR_RESP_OKAY);
      d = 8'($urandom);
      xfer(1'b0, d);
      chk(ack, 1, "data ack");
      rd(`I2CSR_OFS_STATUS, 8'h80, `I2CSR_RESP_OKAY);
      rd(`I2CSR_OFS_DATA, d, `I2CSR_RESP_OKAY);
    end
    wr(`I2CSR_OFS_CONTROL, 8'h84, `I2CSR_RESP_OKAY);
    xfer(1'b0, 8'($urandom));
    chk(ack, 0, "nack after ack enable cleared");
    rd(`I2CSR_OFS_STATUS, 8'h88, `I2CSR_RESP_OKAY);
    wr(`I2CSR_OFS_CONTROL, 8'ha4, `I2CSR_RESP_OKAY);
    // The hold drops one edge after the flag clears
    @(posedge aclk);
    chk(scl_oe, 0, "stretch released");
    i_master.stop();
    repeat (8) @(posedge aclk);
    chk(start_on_free, 1, "start once bus free");
    wr(`I2CSR_OFS_CONTROL, 8'h04, `I2CSR_RESP_OKAY);
    xfer(1'b1, {sa, 1'b0});
    chk(ack, 0, "address ignored");
    i_master.stop();
    wr(`I2CSR_OFS_CONTROL, 8'h44, `I2CSR_RESP_OKAY);
    xfer(1'b1, 8'h00);
    chk(ack, 1, "general call ack");
    rd(`I2CSR_OFS_STATUS, 8'h70, `I2CSR_RESP_OKAY);
    wr(`I2CSR_OFS_CONTROL, 8'hc4, `I2CSR_RESP_OKAY);
    i_master.stop();
    // Lost arbitration then own address, then general call
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      arb_lost <= 1'b1;
      @(posedge aclk);
      arb_lost <= 1'b0;
      xfer(1'b1, i ? 8'h00 : {sa, 1'b0});
      chk(ack, 1, "ack after lost arbitration");
      rd(`I2CSR_OFS_STATUS, i ? 8'h78 : 8'h68, `I2CSR_RESP_OKAY);
      wr(`I2CSR_OFS_CONTROL, 8'hc4, `I2CSR_RESP_OKAY);
      i_master.stop();
    end
    xfer(1'b1, {sa, 1'b1});
    chk(tx_select, 1, "read selects transmitter");
    i_master.stop();
    repeat (8) @(posedge aclk);
    chk(tx_select, 0, "transmitter cleared on stop");
    wr(`I2CSR_OFS_OWN_ADDR, {sa, 1'b0}, `I2CSR_RESP_OKAY);
    xfer(1'b1, 8'h00);
    chk(ack, 0, "general call ignored");
    i_master.stop();
    xfer(1'b1, {sa ^ 7'h01, 1'b0});
    chk(ack, 0, "foreign address ignored");
    i_master.stop();
    @(posedge aclk);
    core_sleep <= 1'b1;
    xfer(1'b1, {sa, 1'b0});
    chk(ack, 1, "ack while asleep");
    chk({wake_request, scl_oe}, 2'b11, "wake and hold");
    rd(`I2CSR_OFS_STATUS, 8'h60, `I2CSR_RESP_OKAY);
    wr(`I2CSR_OFS_CONTROL, 8'hc4, `I2CSR_RESP_OKAY);
    @(posedge aclk);
    chk({wake_request, scl_oe}, 2'b00, "hold ends on clear");
    core_sleep <= 1'b0;
    i_master.stop();
    give_verdict();
  end
endmodule // testbench
